// File: hw/phy_port_strap_defaults.sv
// Strap capture and derivation of port 1 and port 2 reset defaults
//
// Behaviour
// [RQ1] Port 1 duplex strap low gives half duplex default, high full duplex.
// [RQ2] Port 1 duplex strap also sets 10FD advert bit 6, mode field, duplex bit.
// [RQ3] Port 1 backpressure bit defaults to the backpressure strap.
// [RQ4] Port 1 pause send and receive enables default from pause enable strap.
// [RQ5] Send and receive enables govern pause only while manual select is set.
// [RQ6] Manual strap low clears manual select and sets advert pause bit 10.
// [RQ7] Manual strap high sets manual select and clears advert pause bit 10.
// [RQ8] Port 2 auto crossover follows its strap only while override is clear.
// [RQ9] Auto strapped low, override clear: manual strap picks MDI 0 or MDIX 1.
// [RQ10] Port 2 negotiation enable defaults from the negotiation strap.
// [RQ11] Negotiation strap also shapes speed, duplex, advert bits 6, 5, mode. Here speed follows the speed strap alone.
// [RQ12] Port 2 rate select low bit defaults from speed strap: 10 or 100.
// [RQ13] Speed strap also shapes advert bits 6 and 5 and the mode field.
// [RQ14] Straps captured at pin reset release; loader values replace them.
// [RQ15] Digital reset or reload restores captured values, no pin resample.
// [RQ16] Defaults applied in one reset sequence and held until reset.
`timescale 1ns/100ps
`default_nettype none
`include "strap_defaults_map.svh"

module phy_port_strap_defaults
    import strap_defaults_pkg::*;
#(
    parameter logic MANUAL_MDIX_DEFAULT = `MANUAL_MDIX_TIEOFF,
    parameter logic P2_DUPLEX_DEFAULT = 1'h1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_reset_n,
    input wire logic digital_reset,
    input wire logic reload_req,
    input wire logic p1_duplex_pin,
    input wire logic p1_backpressure_strap,
    input wire logic p1_pause_enable_strap,
    input wire logic p1_pause_manual_select_strap,
    input wire logic p2_crossover_auto_pin,
    input wire logic p2_negotiation_pin,
    input wire logic p2_speed_pin,
    input wire logic cfg_mem_present,
    input wire logic loader_valid,
    input wire strap_set_s loader_straps,
    input wire logic crossover_override_bit,
    input wire logic p2_crossover_sw_auto,
    input wire logic p2_crossover_sw_cross,
    output phy_defaults_s p1_phy_defaults,
    output phy_defaults_s p2_phy_defaults,
    output flow_defaults_s p1_flow_defaults,
    output logic p1_pause_tx_active,
    output logic p1_pause_rx_active,
    output logic p2_crossover_auto_en,
    output logic p2_crossover_crossed,
    output logic defaults_load,
    output logic defaults_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Derivation helpers, shared by both ports

    function automatic logic [2:0] mode_of(input logic an, input logic spd,
                                           input logic dup);
        logic [2:0] m;
        m = `MODE_AN_ALL;
        if (!an) begin
            if (spd) begin
                m = dup ? `MODE_100FD : `MODE_100HD;
            end else begin
                m = dup ? `MODE_10FD : `MODE_10HD;
            end
        end else if (spd && !dup) begin
            // Negotiating from 100 at half duplex takes the MODE_AN_100HD mode
            m = `MODE_AN_100HD;
        end
        return m;
    endfunction

    function automatic phy_defaults_s phy_of(input logic an, input logic spd,
                                             input logic dup, input logic manual_fc);
        phy_defaults_s p;
        p = '0;
        p.negotiation_enable_bit = an;
        p.rate_select_low_bit = spd;
        p.halffull_ctrl_bit = dup;
        p.advert[`ADV_SELECTOR_LSB] = 1'h1;
        // Negotiation offers 10 half duplex, and 10 full duplex only at full duplex; a forced link offers only its own speed
        p.advert[`ADV_10HD_BIT] = an || !spd;
        p.advert[`ADV_10FD_BIT] = (an || !spd) && dup;
        p.advert[`ADV_100HD_BIT] = spd;
        p.advert[`ADV_100FD_BIT] = spd && dup;
        p.advert[`ADV_PAUSE_BIT] = !manual_fc;
        p.special_mode = mode_of(an, spd, dup);
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Capture and source selection

    seq_state_e state_ff;
    seq_state_e nxt_state;
    logic pin_reset_n_ff;
    logic loaded_ff;
    logic store_wr;
    logic [`STRAP_ADDR_W-1:0] store_wr_addr;
    strap_set_s store_wr_data;
    strap_set_s pin_set;
    strap_set_s active_set;
    logic [`STRAP_ADDR_W-1:0] rd_addr;
    logic pin_release;
    logic loader_take;

    assign pin_release = pin_reset_n && !pin_reset_n_ff;
    // Loader words count only while a configuration memory is fitted
    assign loader_take = loader_valid && cfg_mem_present;

    always_comb begin
        pin_set = '0;
        pin_set.p1_duplex = p1_duplex_pin;
        pin_set.p1_backpressure_strap = p1_backpressure_strap;
        pin_set.p1_pause_enable_strap = p1_pause_enable_strap;
        pin_set.p1_pause_manual_select_strap = p1_pause_manual_select_strap;
        pin_set.p2_crossover_auto = p2_crossover_auto_pin;
        pin_set.p2_crossover_manual = MANUAL_MDIX_DEFAULT;
        pin_set.p2_negotiation_pin = p2_negotiation_pin;
        pin_set.p2_speed = p2_speed_pin;
    end

    // Release edge of the pin reset, caught by a clocked process
    // Reset to the idle level, so leaving reset is never taken for a release
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_reset_n_ff <= 1'h1;
        end else begin
            pin_reset_n_ff <= pin_reset_n;
        end
    end

    // [RQ14] capture and override
    always_comb begin
        store_wr = 1'b0;
        store_wr_addr = `STRAP_ADDR_LATCHED;
        store_wr_data = pin_set;
        if (pin_release) begin
            store_wr = 1'b1;
        end else if (loader_take) begin
            store_wr = 1'b1;
            store_wr_addr = `STRAP_ADDR_LOADED;
            store_wr_data = loader_straps;
        end
    end

    // [RQ15] digital reset or reload drops loaded values
    // A loader word on the same edge as a reload wins, it is the newer value
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            loaded_ff <= 1'h0;
        end else if (pin_release) begin
            loaded_ff <= 1'h0;
        end else if (loader_take) begin
            loaded_ff <= 1'h1;
        end else if (digital_reset || reload_req) begin
            loaded_ff <= 1'h0;
        end
    end

    assign rd_addr = loaded_ff ? `STRAP_ADDR_LOADED : `STRAP_ADDR_LATCHED;

    strap_store #(
        .WORDS(`STRAP_WORDS),
        .AW(`STRAP_ADDR_W)
    ) u_store (
        .sys_clk(sys_clk),
        .wr_en(store_wr),
        .wr_addr(store_wr_addr),
        .wr_data(store_wr_data),
        .rd_addr(rd_addr),
        .rd_data(active_set)
    );

    ////////////////////////////////////////////////////////////////////////
    // Apply sequence: any capture or reload re-runs it

    logic restart;
    logic apply_now;
    assign restart = pin_release || digital_reset || reload_req || loader_take;
    // A restart on the apply edge discards that apply
    assign apply_now = (state_ff == ST_APPLY) && !restart;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_CAPTURE: nxt_state = ST_APPLY;
            ST_APPLY: nxt_state = ST_HOLD;
            ST_HOLD: nxt_state = restart ? ST_CAPTURE : ST_HOLD;
            // The fourth code is never entered; fall back to idle
            default: nxt_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= ST_HOLD;
        end else if (restart) begin
            state_ff <= ST_CAPTURE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // [RQ16] load pulse, outputs update once and then hold
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            defaults_load <= 1'h0;
            defaults_valid <= 1'h0;
        end else begin
            defaults_load <= apply_now;
            if (restart) begin
                defaults_valid <= 1'h0;
            end else if (state_ff == ST_APPLY) begin
                defaults_valid <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived defaults

    // [RQ1] [RQ2] port 1 duplex, advert bit 6, mode
    // [RQ6] [RQ7] pause advert from manual select
    // Port 1 has no speed or negotiation strap here, so it negotiates from 100
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p1_phy_defaults <= '0;
        end else if (apply_now) begin
            p1_phy_defaults <= phy_of(1'h1, 1'h1, active_set.p1_duplex,
                                      active_set.p1_pause_manual_select_strap);
        end
    end

    // [RQ10] [RQ11] [RQ12] [RQ13] port 2 negotiation and speed
    // Negotiation forces a full duplex default; a fixed link takes the parameter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p2_phy_defaults <= '0;
        end else if (apply_now) begin
            p2_phy_defaults <= phy_of(active_set.p2_negotiation_pin, active_set.p2_speed,
                                      active_set.p2_negotiation_pin || P2_DUPLEX_DEFAULT,
                                      1'h0);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p1_flow_defaults <= '0;
        end else if (apply_now) begin
            // [RQ3] backpressure default
            p1_flow_defaults.p1_backpressure_bit <= active_set.p1_backpressure_strap;
            // [RQ4] pause enables
            p1_flow_defaults.p1_pause_send_enable <= active_set.p1_pause_enable_strap;
            p1_flow_defaults.p1_pause_receive_enable <= active_set.p1_pause_enable_strap;
            // [RQ6] [RQ7] manual select default
            p1_flow_defaults.p1_pause_manual_select <=
                active_set.p1_pause_manual_select_strap;
        end
    end

    // [RQ5] pause gated by manual select
    // One cycle behind the flow defaults, which are themselves registered
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p1_pause_tx_active <= 1'h0;
            p1_pause_rx_active <= 1'h0;
        end else begin
            p1_pause_tx_active <= p1_flow_defaults.p1_pause_manual_select
                                  && p1_flow_defaults.p1_pause_send_enable;
            p1_pause_rx_active <= p1_flow_defaults.p1_pause_manual_select
                                  && p1_flow_defaults.p1_pause_receive_enable;
        end
    end

    // [RQ8] auto crossover, strap ignored under override
    // Until the first pin release the store holds no capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p2_crossover_auto_en <= 1'h0;
        end else if (crossover_override_bit) begin
            p2_crossover_auto_en <= p2_crossover_sw_auto;
        end else begin
            p2_crossover_auto_en <= active_set.p2_crossover_auto;
        end
    end

    // [RQ9] manual crossover strap counts only while auto is strapped off and override is clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            p2_crossover_crossed <= 1'h0;
        end else if (crossover_override_bit) begin
            p2_crossover_crossed <= p2_crossover_sw_cross;
        end else begin
            p2_crossover_crossed <= !active_set.p2_crossover_auto
                                    && active_set.p2_crossover_manual;
        end
    end

endmodule
`default_nettype wire

// File: hw/strap_defaults_map.svh
// Constants for the strap default derivation block
`ifndef STRAP_DEFAULTS_MAP_SVH
`define STRAP_DEFAULTS_MAP_SVH

// Advertisement register bit positions
`define ADV_10HD_BIT 5
`define ADV_10FD_BIT 6
`define ADV_100HD_BIT 7
`define ADV_100FD_BIT 8
`define ADV_PAUSE_BIT 10
`define ADV_SELECTOR_LSB 0

// Special mode field encodings
`define MODE_10HD 3'h0
`define MODE_10FD 3'h1
`define MODE_100HD 3'h2
`define MODE_100FD 3'h3
`define MODE_AN_100HD 3'h4
`define MODE_AN_ALL 3'h7

// Tie-off default of the manual crossover strap
`define MANUAL_MDIX_TIEOFF 1'h0

// Storage geometry of the strap memory
`define STRAP_WORDS 2
`define STRAP_ADDR_W 1
`define STRAP_ADDR_LATCHED 1'h0
`define STRAP_ADDR_LOADED 1'h1

`endif

// File: hw/strap_defaults_pkg.sv
// Types shared by the strap default derivation block
package strap_defaults_pkg;

    // One full set of covered strap values
    typedef struct packed {
        logic p1_duplex;
        logic p1_backpressure_strap;
        logic p1_pause_enable_strap;
        logic p1_pause_manual_select_strap;
        logic p2_crossover_auto;
        logic p2_crossover_manual;
        logic p2_negotiation_pin;
        logic p2_speed;
    } strap_set_s;

    // Derived per-port PHY defaults
    typedef struct packed {
        logic halffull_ctrl_bit;
        logic negotiation_enable_bit;
        logic rate_select_low_bit;
        logic [15:0] advert;
        logic [2:0] special_mode;
    } phy_defaults_s;

    // Derived port 1 manual flow-control defaults
    typedef struct packed {
        logic p1_backpressure_bit;
        logic p1_pause_send_enable;
        logic p1_pause_receive_enable;
        logic p1_pause_manual_select;
    } flow_defaults_s;

    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_APPLY,
        ST_HOLD
    } seq_state_e;

endpackage

// File: hw/strap_store.sv
// Small register memory holding the latched and loaded strap sets
`timescale 1ns/100ps
`default_nettype none
`include "strap_defaults_map.svh"

module strap_store
    import strap_defaults_pkg::*;
#(
    parameter int WORDS = `STRAP_WORDS,
    parameter int AW = `STRAP_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire strap_set_s wr_data,
    input wire logic [AW-1:0] rd_addr,
    output strap_set_s rd_data
);

    strap_set_s mem_ff [WORDS];

    // Contents survive digital reset on purpose; only writes change them
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_data <= mem_ff[rd_addr];
    end

endmodule
`default_nettype wire

// File: tb/phy_port_strap_defaults_sva.sv
// Port-level assertions for the strap default block
`timescale 1ns/100ps
`default_nettype none
module phy_port_strap_defaults_sva
    import strap_defaults_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_reset_n,
    input wire logic digital_reset,
    input wire logic reload_req,
    input wire logic loader_valid,
    input wire logic crossover_override_bit,
    input wire logic p2_crossover_sw_auto,
    input wire phy_defaults_s p1_phy_defaults,
    input wire phy_defaults_s p2_phy_defaults,
    input wire flow_defaults_s p1_flow_defaults,
    input wire logic p1_pause_tx_active,
    input wire logic p2_crossover_auto_en,
    input wire logic defaults_load,
    input wire logic defaults_valid
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
load_pulse_a: assert property (defaults_load |=> !defaults_load)
    else $error("defaults load pulse too long");
load_valid_a: assert property (defaults_load |-> defaults_valid)
    else $error("defaults loaded without valid");
restart_apply_a: assert property ($fell(digital_reset) |-> ##[1:4] defaults_load)
    else $error("digital reset did not reapply defaults");
pause_pair_a: assert property (defaults_load |->
    p1_flow_defaults.p1_pause_send_enable == p1_flow_defaults.p1_pause_receive_enable)
    else $error("pause enables differ");
pause_gate_a: assert property (defaults_load |=> p1_pause_tx_active ==
    (p1_flow_defaults.p1_pause_manual_select && p1_flow_defaults.p1_pause_send_enable))
    else $error("pause activity not gated by manual select");
pause_advert_a: assert property (defaults_load |-> p1_phy_defaults.advert[10] ==
    !p1_flow_defaults.p1_pause_manual_select) else $error("pause advert wrong");
p2_an_mode_a: assert property (defaults_load && p2_phy_defaults.negotiation_enable_bit
    |-> p2_phy_defaults.special_mode == 3'h7) else $error("port 2 negotiation mode wrong");
p2_fixed_mode_a: assert property (defaults_load && !p2_phy_defaults.negotiation_enable_bit
    |-> p2_phy_defaults.special_mode == {1'h0, p2_phy_defaults.rate_select_low_bit,
    p2_phy_defaults.halffull_ctrl_bit}) else $error("port 2 fixed mode wrong");
hold_stable_a: assert property (defaults_valid && $past(defaults_valid) && pin_reset_n
    && $past(pin_reset_n) && !digital_reset && !reload_req && !loader_valid
    |=> $stable(p1_flow_defaults) && $stable(p2_phy_defaults) && $stable(p1_phy_defaults))
    else $error("defaults moved");
override_auto_a: assert property ((crossover_override_bit &&
    $stable(p2_crossover_sw_auto))[*4] |-> p2_crossover_auto_en == p2_crossover_sw_auto)
    else $error("override crossover ignored");
load_c: cover property (defaults_load);
manual_c: cover property (defaults_load && p1_flow_defaults.p1_pause_manual_select);
override_c: cover property (crossover_override_bit && p2_crossover_auto_en);
endmodule
`default_nettype wire

// File: tb/strap_board.sv
// Board side model: pin reset pulse and configuration loader bus
`timescale 1ns/100ps
`default_nettype none
module strap_board
    import strap_defaults_pkg::*;
(
    input wire logic sys_clk,
    input wire logic por_req,
    input wire logic load_req,
    input wire strap_set_s load_set,
    output logic pin_reset_n,
    output strap_set_s loader_straps,
    output logic loader_valid
);
logic [2:0] cnt_ff = 3'h0;
strap_set_s bus_ff = '0;
logic vld_ff = 1'h0;
always_ff @(posedge sys_clk) begin
    cnt_ff <= por_req ? 3'h5 : ((cnt_ff != 3'h0) ? cnt_ff - 3'h1 : cnt_ff);
end
assign pin_reset_n = (cnt_ff == 3'h0);
// loader override delivery
// Idle bus toggles so a stale set is never mistaken for data
always_ff @(posedge sys_clk) begin
    vld_ff <= load_req;
    bus_ff <= load_req ? load_set : ~bus_ff;
end
assign loader_straps = bus_ff;
assign loader_valid = vld_ff;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the strap default block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import strap_defaults_pkg::*;
;
logic sys_clk, rst_n, por_req, load_req, mem_present, dig_rst, reload, ovr, sw_auto, sw_cross;
logic pin_reset_n, loader_valid, tx_act, rx_act, cr_auto, cr_cross, d_load, d_valid;
strap_set_s board_set, load_set, loader_straps;
phy_defaults_s p1_phy, p2_phy;
flow_defaults_s flow;
int failures, check_count;
strap_set_s pats [5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'hC3};
strap_board i_strap_board (.sys_clk(sys_clk), .por_req(por_req), .load_req(load_req),
    .load_set(load_set), .pin_reset_n(pin_reset_n), .loader_straps(loader_straps),
    .loader_valid(loader_valid));
phy_port_strap_defaults i_phy_port_strap_defaults (.sys_clk(sys_clk), .rst_n(rst_n),
    .pin_reset_n(pin_reset_n), .digital_reset(dig_rst), .reload_req(reload),
    .p1_duplex_pin(board_set.p1_duplex), .p1_backpressure_strap(board_set.p1_backpressure_strap),
    .p1_pause_enable_strap(board_set.p1_pause_enable_strap),
    .p1_pause_manual_select_strap(board_set.p1_pause_manual_select_strap),
    .p2_crossover_auto_pin(board_set.p2_crossover_auto),
    .p2_negotiation_pin(board_set.p2_negotiation_pin), .p2_speed_pin(board_set.p2_speed),
    .cfg_mem_present(mem_present), .loader_valid(loader_valid), .loader_straps(loader_straps),
    .crossover_override_bit(ovr), .p2_crossover_sw_auto(sw_auto),
    .p2_crossover_sw_cross(sw_cross), .p1_phy_defaults(p1_phy), .p2_phy_defaults(p2_phy),
    .p1_flow_defaults(flow), .p1_pause_tx_active(tx_act), .p1_pause_rx_active(rx_act),
    .p2_crossover_auto_en(cr_auto), .p2_crossover_crossed(cr_cross), .defaults_load(d_load),
    .defaults_valid(d_valid));
////////////////////////////////////////////////////////////////////////////////
task results;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
        failures++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task cmp_bit(input logic got, input logic exp);
    cmp({7'h0, got}, {7'h0, exp});
endtask
task wait_load;
    int i;
    i = 0;
    do begin
        @(negedge sys_clk);
        i++;
    end while (d_load !== 1'b1 && i < 20);
    cmp_bit(d_load, 1'b1);
endtask
task check_set(input strap_set_s s);
    cmp_bit(d_valid, 1'b1);
    cmp_bit(p1_phy.halffull_ctrl_bit, s.p1_duplex);
    cmp({5'h0, p1_phy.special_mode}, s.p1_duplex ? 8'h07 : 8'h04);
    cmp_bit(p1_phy.advert[6], s.p1_duplex);
    cmp_bit(p1_phy.advert[10], !s.p1_pause_manual_select_strap);
    cmp({4'h0, flow}, {4'h0, s.p1_backpressure_strap, s.p1_pause_enable_strap,
        s.p1_pause_enable_strap, s.p1_pause_manual_select_strap});
    cmp_bit(p2_phy.negotiation_enable_bit, s.p2_negotiation_pin);
    cmp_bit(p2_phy.rate_select_low_bit, s.p2_speed);
    cmp_bit(p2_phy.halffull_ctrl_bit, 1'b1);
    cmp_bit(p2_phy.advert[5], s.p2_negotiation_pin | !s.p2_speed);
    cmp_bit(p2_phy.advert[6], s.p2_negotiation_pin | !s.p2_speed);
    cmp({5'h0, p2_phy.special_mode},
        s.p2_negotiation_pin ? 8'h07 : {6'h0, s.p2_speed, 1'h1});
    repeat (2) @(negedge sys_clk);
    cmp_bit(tx_act, s.p1_pause_manual_select_strap & s.p1_pause_enable_strap);
    cmp_bit(rx_act, s.p1_pause_manual_select_strap & s.p1_pause_enable_strap);
    cmp_bit(cr_auto, s.p2_crossover_auto);
    if (!s.p2_crossover_auto) cmp_bit(cr_cross, s.p2_crossover_manual);
endtask
task por(input strap_set_s p);
    @(posedge sys_clk);
    board_set <= p;
    por_req <= 1'b1;
    @(posedge sys_clk);
    por_req <= 1'b0;
    wait_load;
endtask
task load(input strap_set_s p);
    @(posedge sys_clk);
    load_set <= p;
    load_req <= 1'b1;
    @(posedge sys_clk);
    load_req <= 1'b0;
    wait_load;
endtask
task restart(input logic use_reload);
    @(posedge sys_clk);
    dig_rst <= !use_reload;
    reload <= use_reload;
    @(posedge sys_clk);
    dig_rst <= 1'b0;
    reload <= 1'b0;
    @(negedge sys_clk);
    cmp_bit(d_valid, 1'b0);
    wait_load;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
end
initial begin
    #100us;
    failures++;
    results;
end
initial begin
    {rst_n, por_req, load_req, mem_present, dig_rst, reload, ovr, sw_auto, sw_cross} = '0;
    board_set = '0;
    load_set = '0;
    failures = 0;
    check_count = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Manual crossover has no pin, so pin sets carry its tie-off of zero
    foreach (pats[i]) begin
        por(pats[i] & 8'hFB);
        check_set(pats[i] & 8'hFB);
    end
    // Without a configuration memory a loader word must change nothing
    @(posedge sys_clk);
    load_set <= 8'h36;
    load_req <= 1'b1;
    @(posedge sys_clk);
    load_req <= 1'b0;
    repeat (6) @(negedge sys_clk);
    cmp_bit(d_load, 1'b0);
    check_set(8'hC3);
    @(posedge sys_clk);
    mem_present <= 1'b1;
    board_set <= 8'hFF;
    load(8'h36);
    check_set(8'h36);
    restart(1'b0);
    check_set(8'hC3);
    load(8'h36);
    restart(1'b1);
    check_set(8'hC3);
    for (int v = 1; v >= 0; v--) begin
        @(posedge sys_clk);
        ovr <= 1'b1;
        sw_auto <= v[0];
        sw_cross <= v[0];
        repeat (4) @(negedge sys_clk);
        cmp_bit(cr_auto, v[0]);
        cmp_bit(cr_cross, v[0]);
    end
    results;
end
endmodule
bind phy_port_strap_defaults phy_port_strap_defaults_sva i_sva (.sys_clk(sys_clk),
    .rst_n(rst_n), .pin_reset_n(pin_reset_n), .digital_reset(digital_reset),
    .reload_req(reload_req), .loader_valid(loader_valid),
    .crossover_override_bit(crossover_override_bit),
    .p2_crossover_sw_auto(p2_crossover_sw_auto), .p1_phy_defaults(p1_phy_defaults),
    .p2_phy_defaults(p2_phy_defaults), .p1_flow_defaults(p1_flow_defaults),
    .p1_pause_tx_active(p1_pause_tx_active), .p2_crossover_auto_en(p2_crossover_auto_en),
    .defaults_load(defaults_load), .defaults_valid(defaults_valid));
`default_nettype wire
